/* inc/srh_params.svh */
// timing counts, pin reset levels and widths for the static ram host controller
`ifndef SRH_PARAMS_SVH
`define SRH_PARAMS_SVH
// clock rate and period in ns
`define SRH_CLK_MHZ 40
`define SRH_CLK_NS (1000 / `SRH_CLK_MHZ)
// least time in ns rounded up to whole cycles, never below one
`define SRH_CYC(t) ((((t) + `SRH_CLK_NS - 1) / `SRH_CLK_NS) < 1 ? 1 : \
	(((t) + `SRH_CLK_NS - 1) / `SRH_CLK_NS))
// memory shape
`define SRH_ADDR_W 13
`define SRH_DATA_W 8
// interface times in ns
`define SRH_T_AS_NS 0
`define SRH_T_AW_NS 85
`define SRH_T_WP_NS 70
`define SRH_RECOVERY_AFTER_STROBE_END_NS 5
`define SRH_RECOVERY_AFTER_HIGH_SELECT_END_NS 15
`define SRH_T_RC_NS 120
`define SRH_T_OHZ_NS 40
`define SRH_DESELECT_BEFORE_RETENTION_NS 0
// derived cycle counts
`define SRH_SET_CYC `SRH_CYC(`SRH_T_AS_NS)
`define SRH_STB_CYC `SRH_CYC(`SRH_T_AW_NS)
`define SRH_WR1_CYC `SRH_CYC(`SRH_RECOVERY_AFTER_STROBE_END_NS)
`define SRH_WR2_CYC `SRH_CYC(`SRH_RECOVERY_AFTER_HIGH_SELECT_END_NS)
`define SRH_RC_CYC `SRH_CYC(`SRH_T_RC_NS)
`define SRH_TURN_CYC `SRH_CYC(`SRH_T_OHZ_NS)
// pin levels held during reset
`define SRH_RST_SEL_N 1'b1
`define SRH_RST_SEL_H 1'b1
`define SRH_RST_WE_N 1'b1
`define SRH_RST_OE_N 1'b1
`endif

/* inc/srh_pkg.sv */
// types shared by the static ram host controller
package srh_pkg;
	// one-hot controller states
	typedef enum logic [7:0] {
		SRH_IDLE = 8'h01,
		SRH_WSET = 8'h02,
		SRH_WSTB = 8'h04,
		SRH_WREC = 8'h08,
		SRH_READ = 8'h10,
		SRH_TURN = 8'h20,
		SRH_RET = 8'h40,
		SRH_REXIT = 8'h80
	} srh_state_t;
endpackage : srh_pkg

/* core/srh_tmr.sv */
// down counter that times how long the controller stays in a state
`timescale 1ns/1ps
`default_nettype none
module srh_tmr #(
	parameter int W = 3
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic load_in, // restart with value_in
	input wire logic [W-1:0] value_in,
	output logic done_out // count has reached zero
);
	logic [W-1:0] cnt; // remaining cycles minus one
	logic [W-1:0] next_cnt;

	generate
		if (W < 1) begin : g_bad_w
			$error("srh_tmr: width must be at least one");
		end
	endgenerate

	// load or count down, holding at zero
	always_comb begin
		if (load_in) begin
			next_cnt = value_in;
		end else if (cnt != '0) begin
			next_cnt = cnt - W'(1);
		end else begin
			next_cnt = cnt;
		end
	end

	// counter register
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign done_out = (cnt == '0);
endmodule : srh_tmr
`default_nettype wire

/* core/srh_ctrl.sv */
// host controller driving an asynchronous 8k by 8 static ram over its pins
`timescale 1ns/1ps
`default_nettype none
`include "srh_params.svh"

// Overview of operation
// RULE_01 - ram holds 8192 bytes, one shared bus
// RULE_02 - write needs both selects and strobe active
// RULE_03 - write starts at the last asserting edge
// RULE_04 - write ends at the first releasing edge
// RULE_05 - address valid before and through write
// RULE_06 - recovery before address change matches ending signal
// RULE_07 - late select fall keeps ram outputs off
// RULE_08 - never fight the ram driving data
// RULE_09 - output low write shows written data
// RULE_10 - new address then gives normal read data
// RULE_11 - write ignores output enable level
// RULE_12 - read: strobe high, selected, output low
// RULE_13 - read data follows the address
// RULE_14 - deselect floats bus, enters standby
// RULE_15 - output enable high floats bus when selected
// RULE_16 - high select low gates all other inputs
// RULE_17 - low select retention keeps high select firm
// RULE_18 - deselect before supply drop, wait after
// RULE_19 - round intervals up, strobe inside select
module srh_ctrl #(
	parameter int ADDR_W = `SRH_ADDR_W,
	parameter int DATA_W = `SRH_DATA_W,
	parameter int TMR_W = 3
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic req_in, // access request, taken while ready_out
	input wire logic wr_in, // 1 write, 0 read
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic ret_req_in, // ask for data retention
	input wire logic ret_by_high_in, // retention through the high select
	input wire logic supply_ok_in, // ram supply back at full level
	output logic ready_out, // idle, may take a request
	output logic [DATA_W-1:0] rdata_out,
	output logic rvalid_out, // one-cycle read data pulse
	output logic retention_out, // ram deselected, supply may drop
	output logic [ADDR_W-1:0] mem_addr_out,
	output logic select_active_low_n_out,
	output logic select_active_high_out,
	output logic we_n_out,
	output logic oe_n_out,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe_out // high while we drive the data pins
);
	srh_pkg::srh_state_t state; // controller state
	srh_pkg::srh_state_t next_state;
	logic next_ready;
	logic [DATA_W-1:0] next_rdata;
	logic next_rvalid;
	logic next_retention;
	logic [ADDR_W-1:0] next_mem_addr;
	logic next_sel_n;
	logic next_sel_h;
	logic next_we_n;
	logic next_oe_n;
	logic [DATA_W-1:0] next_dq;
	logic next_dq_oe;
	logic tmr_load; // restart the state timer
	logic [TMR_W-1:0] tmr_value; // cycles in the new state minus one
	logic tmr_done; // current state has lasted its time

	// refuse shapes the counts and the ram cannot serve
	generate
		if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_shape
			$error("srh_ctrl: address and data widths must be positive");
		end
		if (`SRH_RC_CYC > (1 << TMR_W) || `SRH_STB_CYC > (1 << TMR_W)) begin : g_bad_tmr
			$error("srh_ctrl: timer too narrow for the cycle counts");
		end
	endgenerate

	// state timer
	srh_tmr #(.W(TMR_W)) i_srh_tmr (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.load_in(tmr_load),
		.value_in(tmr_value),
		.done_out(tmr_done)
	);

	// next state and next pin levels
	always_comb begin
		next_state = state;
		next_ready = ready_out | (state == srh_pkg::SRH_IDLE); // idle stays ready unless a request or retention is taken
		next_rdata = rdata_out;
		next_rvalid = 1'b0;
		next_retention = retention_out;
		next_mem_addr = mem_addr_out;
		next_sel_n = select_active_low_n_out;
		next_sel_h = select_active_high_out;
		next_we_n = we_n_out;
		next_oe_n = oe_n_out;
		next_dq = dq_out;
		next_dq_oe = dq_oe_out;
		tmr_load = 1'b0;
		tmr_value = '0;
		case (state)
			srh_pkg::SRH_IDLE: begin
				if (ret_req_in) begin
					// deselect in the same edge that grants retention [RULE_18]
					next_state = srh_pkg::SRH_RET;
					next_ready = 1'b0;
					next_retention = 1'b1;
					next_sel_n = 1'b1;
					next_sel_h = !ret_by_high_in; // low gates all inputs [RULE_16], else firm high [RULE_17]
				end else if (req_in && ready_out) begin
					// address goes out with the selects, before any strobe [RULE_05]
					next_ready = 1'b0;
					next_mem_addr = addr_in;
					next_sel_n = 1'b0;
					next_sel_h = 1'b1;
					if (wr_in) begin
						// selects first, strobe later keeps ram outputs off [RULE_07]
						next_state = srh_pkg::SRH_WSET;
						next_dq = wdata_in;
						next_dq_oe = 1'b1;
						tmr_load = 1'b1;
						tmr_value = TMR_W'(`SRH_SET_CYC - 1);
					end else begin
						// strobe high, selected, output enabled [RULE_12]
						next_state = srh_pkg::SRH_READ;
						next_oe_n = 1'b0;
						tmr_load = 1'b1;
						tmr_value = TMR_W'(`SRH_RC_CYC - 1);
					end
				end
			end
			srh_pkg::SRH_WSET: begin
				if (tmr_done) begin
					// strobe falls last, opening the write [RULE_03] [RULE_02]
					next_state = srh_pkg::SRH_WSTB;
					next_we_n = 1'b0;
					tmr_load = 1'b1;
					tmr_value = TMR_W'(`SRH_STB_CYC - 1);
				end
			end
			srh_pkg::SRH_WSTB: begin
				if (tmr_done) begin
					// strobe rises first, closing the write [RULE_04] [RULE_19]
					next_state = srh_pkg::SRH_WREC;
					next_we_n = 1'b1;
					tmr_load = 1'b1;
					tmr_value = TMR_W'(`SRH_WR1_CYC - 1);
				end
			end
			srh_pkg::SRH_WREC: begin
				// strobe ended the write, so the strobe recovery applies [RULE_06]
				if (tmr_done) begin
					next_state = srh_pkg::SRH_IDLE;
					next_ready = 1'b1;
					next_sel_n = 1'b1;
					next_dq_oe = 1'b0;
				end
			end
			srh_pkg::SRH_READ: begin
				if (tmr_done) begin
					// sample after a full read cycle time [RULE_13]
					next_state = srh_pkg::SRH_TURN;
					next_rdata = dq_in;
					next_rvalid = 1'b1;
					next_oe_n = 1'b1;
					next_sel_n = 1'b1;
					tmr_load = 1'b1;
					tmr_value = TMR_W'(`SRH_TURN_CYC - 1);
				end
			end
			srh_pkg::SRH_TURN: begin
				// let the ram outputs float before anyone drives the bus [RULE_08]
				if (tmr_done) begin
					next_state = srh_pkg::SRH_IDLE;
					next_ready = 1'b1;
				end
			end
			srh_pkg::SRH_RET: begin
				if (!ret_req_in && supply_ok_in) begin
					// supply is back, wait one read cycle time [RULE_18]
					next_state = srh_pkg::SRH_REXIT;
					next_retention = 1'b0;
					next_sel_h = 1'b1;
					tmr_load = 1'b1;
					tmr_value = TMR_W'(`SRH_RC_CYC - 1);
				end
			end
			srh_pkg::SRH_REXIT: begin
				if (tmr_done) begin
					next_state = srh_pkg::SRH_IDLE;
					next_ready = 1'b1;
				end
			end
			default: begin
				// unknown code: return to a safe deselected idle
				next_state = srh_pkg::SRH_IDLE;
				next_ready = 1'b1;
				next_retention = 1'b0;
				next_sel_n = 1'b1;
				next_sel_h = 1'b1;
				next_we_n = 1'b1;
				next_oe_n = 1'b1;
				next_dq_oe = 1'b0;
			end
		endcase
	end

	// state and pin registers
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= srh_pkg::SRH_IDLE;
			ready_out <= 1'b0;
			rdata_out <= '0;
			rvalid_out <= 1'b0;
			retention_out <= 1'b0;
			mem_addr_out <= '0;
			select_active_low_n_out <= `SRH_RST_SEL_N;
			select_active_high_out <= `SRH_RST_SEL_H;
			we_n_out <= `SRH_RST_WE_N;
			oe_n_out <= `SRH_RST_OE_N;
			dq_out <= '0;
			dq_oe_out <= 1'b0;
		end else begin
			state <= next_state;
			ready_out <= next_ready;
			rdata_out <= next_rdata;
			rvalid_out <= next_rvalid;
			retention_out <= next_retention;
			mem_addr_out <= next_mem_addr;
			select_active_low_n_out <= next_sel_n;
			select_active_high_out <= next_sel_h;
			we_n_out <= next_we_n;
			oe_n_out <= next_oe_n;
			dq_out <= next_dq;
			dq_oe_out <= next_dq_oe;
		end
	end

	// checks on the pin sequences
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	property p_strobe_in_select;
		!we_n_out |-> !select_active_low_n_out && select_active_high_out;
	endproperty
	a_strobe_in_select: assert property (p_strobe_in_select) // [RULE_02]
		else $error("write strobe outside the select window");
	property p_strobe_width;
		$fell(we_n_out) |-> !we_n_out [*4] ##1 we_n_out;
	endproperty
	a_strobe_width: assert property (p_strobe_width) // [RULE_03]
		else $error("write strobe width wrong");
	property p_addr_stable;
		(!we_n_out || $past(!we_n_out)) |-> $stable(mem_addr_out);
	endproperty
	a_addr_stable: assert property (p_addr_stable) // [RULE_05]
		else $error("address moved during write or recovery");
	property p_recovery;
		$rose(we_n_out) |-> !select_active_low_n_out && dq_oe_out ##1 select_active_low_n_out;
	endproperty
	a_recovery: assert property (p_recovery) // [RULE_06]
		else $error("write recovery not one cycle");
	property p_no_fight;
		!oe_n_out |-> !dq_oe_out && we_n_out;
	endproperty
	a_no_fight: assert property (p_no_fight) // [RULE_08]
		else $error("data driven while ram output enabled");
	property p_turnaround;
		$rose(oe_n_out) |-> !dq_oe_out [*3];
	endproperty
	a_turnaround: assert property (p_turnaround) // [RULE_08]
		else $error("bus driven too soon after read");
	property p_read_cycle;
		$fell(oe_n_out) |-> !oe_n_out [*5] ##1 (oe_n_out && rvalid_out);
	endproperty
	a_read_cycle: assert property (p_read_cycle) // [RULE_12]
		else $error("read cycle length or data pulse wrong");
	property p_ret_deselected;
		retention_out |-> (select_active_low_n_out || !select_active_high_out) && !dq_oe_out;
	endproperty
	a_ret_deselected: assert property (p_ret_deselected) // [RULE_18]
		else $error("retention without deselect");
	property p_ret_exit;
		$fell(retention_out) |-> !ready_out [*5] ##1 ready_out;
	endproperty
	a_ret_exit: assert property (p_ret_exit) // [RULE_18]
		else $error("retention exit wait wrong");
	c_write: cover property ($rose(we_n_out));
	c_read: cover property (rvalid_out);
	c_ret_high: cover property (retention_out && !select_active_high_out);
	c_ret_low: cover property (retention_out && select_active_high_out);
endmodule : srh_ctrl
`default_nettype wire

/* dv/srh_ram_model.sv */
// behavioural model of the 8k by 8 static ram seen at the controller pins
`timescale 1ns/1ps
`default_nettype none
module srh_ram_model (
	input wire logic [12:0] addr_in,
	input wire logic select_active_low_n_in, // active low select
	input wire logic select_active_high_in, // active high select
	input wire logic we_n_in, // write strobe, low writes
	input wire logic oe_n_in, // output enable, low reads
	input wire logic [7:0] ctl_dq_in, // value the controller drives
	input wire logic ctl_oe_in, // controller drives the pins
	output logic [7:0] bus_out, // level seen on the data pins
	output int fault_out // count of pin protocol faults
);
	logic [7:0] mem [0:8191]; // storage, one byte a word
	logic [7:0] last = 8'h00; // last driven level, for a floating bus
	logic wr_act; // overlap of both selects and the strobe
	logic ram_drv; // ram drives the pins
	logic wr_on = 1'b0; // a write overlap is under way
	realtime t_end = 0.0; // end time of the last write
	realtime t_rec = 0.0; // recovery owed after that write
	initial fault_out = 0;
	// high select low gates every other input
	assign wr_act = !select_active_low_n_in && select_active_high_in && !we_n_in;
	assign ram_drv = !select_active_low_n_in && select_active_high_in && we_n_in && !oe_n_in;
	// store while the overlap lasts, whatever output enable does
	always @(wr_act, bus_out, addr_in) begin
		if (wr_act) begin
			mem[addr_in] = bus_out;
		end
	end
	// pin level: controller, else ram, else a float at the inverse of the last driven level
	always @* begin
		if (ctl_oe_in) begin
			bus_out = ctl_dq_in;
		end else if (ram_drv) begin
			bus_out = mem[addr_in]; // fresh write, then new address
		end else begin
			bus_out = ~last;
		end
	end
	// remember the last driven level
	always @(ctl_oe_in, ctl_dq_in, ram_drv, addr_in) begin
		if (ctl_oe_in || ram_drv) begin
			last = ctl_oe_in ? ctl_dq_in : mem[addr_in];
		end
	end
	// recovery depends on which select ended the write
	// only a real end of a write opens a recovery window, not the settling at reset
	always @(wr_act) begin
		if (wr_act === 1'b1) begin
			wr_on = 1'b1;
		end else if (wr_on) begin
			wr_on = 1'b0;
			t_end = $realtime;
			t_rec = (select_active_high_in === 1'b1) ? 5.0 : 15.0;
		end
	end
	// address must hold through the write and its recovery
	always @(addr_in) begin
		if (wr_act || ($realtime - t_end < t_rec)) begin
			fault_out++;
		end
	end
	// no fight on the data pins, high select firm while deselected
	always @(ctl_oe_in, ram_drv, select_active_low_n_in, select_active_high_in) begin
		if (ctl_oe_in && ram_drv) begin
			fault_out++;
		end
		if (select_active_low_n_in && $isunknown(select_active_high_in)) begin
			fault_out++;
		end
	end
endmodule : srh_ram_model
`default_nettype wire

/* dv/srh_ctrl_bench.sv */
// self-checking bench for the static ram host controller with its ram model
`timescale 1ns/1ps
`default_nettype none
module srh_ctrl_bench;
	logic ref_clk = 1'b0; // 40 MHz clock
	logic arst_n = 1'b0; // reset, active low
	logic req = 1'b0;
	logic wr = 1'b0;
	logic [12:0] addr = 13'h0000;
	logic [7:0] wdata = 8'h00;
	logic ret_req = 1'b0;
	logic ret_by_high = 1'b0;
	logic supply_ok = 1'b1;
	logic ready, rvalid, retention, sel_n, sel_h, we_n, oe_n, dq_oe;
	logic [7:0] rdata, dq_out, bus;
	logic [12:0] mem_addr;
	int fault; // pin faults seen by the ram model
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	logic [12:0] addrs [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
	logic [7:0] datas [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
	srh_ctrl i_srh_ctrl (.ref_clk_in(ref_clk), .arst_n_in(arst_n), .req_in(req), .wr_in(wr),
		.addr_in(addr), .wdata_in(wdata), .ret_req_in(ret_req), .ret_by_high_in(ret_by_high),
		.supply_ok_in(supply_ok), .ready_out(ready), .rdata_out(rdata), .rvalid_out(rvalid),
		.retention_out(retention), .mem_addr_out(mem_addr), .select_active_low_n_out(sel_n),
		.select_active_high_out(sel_h), .we_n_out(we_n), .oe_n_out(oe_n), .dq_in(bus),
		.dq_out(dq_out), .dq_oe_out(dq_oe));
	srh_ram_model i_srh_ram_model (.addr_in(mem_addr), .select_active_low_n_in(sel_n),
		.select_active_high_in(sel_h), .we_n_in(we_n), .oe_n_in(oe_n), .ctl_dq_in(dq_out),
		.ctl_oe_in(dq_oe), .bus_out(bus), .fault_out(fault));
	// free running clock
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	// cut a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// verdict and end of run
	task automatic close_out();
		if (error_cnt == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	// compare one pin or flag
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_bit
	// compare one data byte
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_byte
	// compare a cycle or fault count
	task automatic chk_num(input int got, input int exp);
		check_count++;
		if (got != exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_num
	// step to just after the next rising edge
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick
	// one host access; cycles to read data and to ready after the taking edge
	task automatic access(input logic w, input logic [12:0] a, input logic [7:0] d,
		output int n_rv, output int n_rdy, output logic [7:0] got);
		int n;
		n = 0;
		n_rv = 0;
		got = 8'h00;
		while (ready !== 1'b1 && n < 40) begin
			tick();
			n++;
		end
		req = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		tick();
		req = 1'b0;
		n = 1;
		while (ready !== 1'b1 && n < 40) begin
			if (rvalid === 1'b1) begin
				n_rv = n;
				got = rdata;
			end
			tick();
			n++;
		end
		n_rdy = n;
	endtask : access
	// pins parked while reset is held
	task automatic t_reset();
		repeat (5) @(posedge ref_clk);
		#1;
		chk_bit(sel_n, 1'b1);
		chk_bit(we_n, 1'b1);
		chk_bit(dq_oe, 1'b0);
		arst_n = 1'b1;
	endtask : t_reset
	// back to back writes at both ends of the array, then read back
	task automatic t_wr_rd();
		int nv, nr;
		logic [7:0] got;
		for (int i = 0; i < 4; i++) begin
			access(1'b1, addrs[i], datas[i], nv, nr, got);
			chk_num(nr, 7);
		end
		for (int i = 0; i < 4; i++) begin
			access(1'b0, addrs[i], 8'h00, nv, nr, got);
			chk_byte(got, datas[i]);
			chk_num(nv, 6);
			chk_num(nr, 8);
		end
	endtask : t_wr_rd
	// a request held while busy must not start a second write
	task automatic t_refuse();
		int nv, nr;
		logic [7:0] got;
		req = 1'b1;
		wr = 1'b1;
		addr = 13'h0aaa;
		wdata = 8'h3c;
		tick();
		addr = 13'h1fff;
		wdata = 8'hc3;
		repeat (3) tick();
		req = 1'b0;
		access(1'b0, 13'h0aaa, 8'h00, nv, nr, got);
		chk_byte(got, 8'h3c);
		access(1'b0, 13'h1fff, 8'h00, nv, nr, got);
		chk_byte(got, 8'h5a);
	endtask : t_refuse
	// retention through either select, supply late, data kept
	task automatic t_ret(input logic by_high);
		int n, nv, nr;
		logic [7:0] got;
		ret_req = 1'b1;
		ret_by_high = by_high;
		supply_ok = 1'b0;
		tick();
		chk_bit(retention, 1'b1);
		chk_bit(sel_n, 1'b1);
		chk_bit(sel_h, !by_high);
		req = 1'b1;
		wr = 1'b1;
		addr = 13'h0000;
		wdata = 8'h99;
		ret_req = 1'b0;
		repeat (3) tick();
		chk_bit(retention, 1'b1);
		chk_bit(we_n, 1'b1);
		req = 1'b0;
		supply_ok = 1'b1;
		tick();
		chk_bit(retention, 1'b0);
		n = 1;
		while (ready !== 1'b1 && n < 40) begin
			tick();
			n++;
		end
		chk_num(n, 6);
		access(1'b0, 13'h0000, 8'h00, nv, nr, got);
		chk_byte(got, 8'ha5);
	endtask : t_ret
	// main sequence
	initial begin
		t_reset();
		t_wr_rd();
		t_refuse();
		t_ret(1'b1);
		t_ret(1'b0);
		chk_num(fault, 0);
		close_out();
	end
endmodule : srh_ctrl_bench
`default_nettype wire
